// *** hdl/serial_port_map.svh ***
// Constants for the shared I2C/SPI register access port
`ifndef SERIAL_PORT_MAP_SVH
`define SERIAL_PORT_MAP_SVH

// Upper six bits of the I2C target address; the last bit comes from the pin
`define TARGET_ADDR_HI 6'h35
// Bit counter value of the eighth and last bit of a byte
`define BIT_LAST 3'h7
// Bit counter value of the first bit of a byte
`define BIT_FIRST 3'h0
// Direction bit value meaning read, for both I2C and SPI
`define DIR_READ 1'h1
// Level that the receiver drives as acknowledge
`define ACK_LEVEL 1'h0
// Step of the register address in bursts
`define ADDR_STEP 8'h01
// Idle level of the CS, SCL, SDA and address-select pins
`define PIN_IDLE 4'hF
// Reset value of an 8-bit data or address register
`define BYTE_ZERO 8'h00

`endif

// *** hdl/serial_port_pkg.sv ***
// Types shared by the serial register access port
package serial_port_pkg;

	typedef enum logic [3:0] {
		st_idle,
		st_addr,
		st_addr_ack,
		st_sub,
		st_sub_ack,
		st_wdata,
		st_wack,
		st_rdata,
		st_rack
	} i2c_state_t;

	typedef enum logic {
		ph_cmd,
		ph_data
	} spi_phase_t;

endpackage : serial_port_pkg

// *** hdl/pin_sync.sv ***
// Two flip-flop synchroniser for levels entering the ref_clk_i domain
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] q_reg;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_reg <= RESET_VAL;
			q_reg <= RESET_VAL;
		end
		else
		begin
			meta_reg <= d_i;
			q_reg <= meta_reg;
		end
	end

	assign q_o = q_reg;

endmodule : pin_sync

`default_nettype wire

// *** hdl/serial_register_access_port.sv ***
// Target-side I2C/SPI register access port sharing one set of pins
//
// What this block does
// - CS high selects I2C; CS low selects SPI and disables I2C.
// - I2C address is 110101 plus the address select pin level.
// - First byte after start is 7-bit address then direction bit.
// - Each received byte is acknowledged by holding SDA low for a clock.
// - I2C write: address, subaddress, data bytes, each acknowledged, then stop.
// - I2C read: device sends bytes; controller acks, ends with nack and stop.
// - Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// - Bytes are eight bits, MSB first, any number per transfer.
// - Device leaves SDA high when it does not accept the address.
// - I2C works at fast mode and fast mode plus clock rates.
// - An I2C disable control switches the I2C logic off.
// - Bursts advance the register address per byte when auto-increment is set.
// - SPI works in clock modes 0 and 3.
// - CS low frames an SPI transaction; clock idles high with CS high.
// - Data is driven on falling clock edges and sampled on rising edges.
// - Access is 16 clocks; each further burst byte adds 8 clocks.
// - Bit 0 starts after CS falls; the last bit ends at CS rise.
// - SPI bit 0 is direction, bits 1-7 address, then data MSB first.
// - On SPI read the device drives data from the start of bit 8.
// - Three-wire select returns SPI read data on the shared data pin.
`timescale 1ns/10ps
`default_nettype none
`include "serial_port_map.svh"

module serial_register_access_port (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic chip_select_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	input wire logic address_select_pin_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	input wire logic auto_inc_i,
	input wire logic three_wire_select_i,
	input wire logic i2c_disable_i,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [7:0] reg_rdata_i
);

	logic rst_n_s;
	logic [3:0] pins_s;
	logic cs_s;
	logic scl_s;
	logic sda_s;
	logic addr_sel_s;

	serial_port_pkg::i2c_state_t state_reg, state_next;
	serial_port_pkg::spi_phase_t phase_reg, phase_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic rw_reg, rw_next;
	logic wr_reg, wr_next;
	logic rd_reg, rd_next;
	logic sda_out_reg, sda_out_next;
	logic sda_oe_reg, sda_oe_next;
	logic sdo_out_reg, sdo_out_next;
	logic sdo_oe_reg, sdo_oe_next;
	logic scl_prev_reg, scl_prev_next;
	logic sda_prev_reg, sda_prev_next;
	logic cs_prev_reg, cs_prev_next;

	logic scl_rise;
	logic scl_fall;
	logic i2c_en;
	logic start_cond;
	logic stop_cond;
	logic [7:0] rx_byte;
	logic addr_match;

	// Reset is released through two flops so every flop leaves reset together
	pin_sync #(
		.WIDTH(1),
		.RESET_VAL(1'b0)
	) u_rst_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.d_i(1'b1),
		.q_o(rst_n_s)
	);

	// Pins reset to their idle high level so release causes no false edge
	pin_sync #(
		.WIDTH(4),
		.RESET_VAL(`PIN_IDLE)
	) u_pin_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(rst_n_s),
		.d_i({chip_select_n_i, scl_i, sda_i, address_select_pin_i}),
		.q_o(pins_s)
	);

	assign cs_s = pins_s[3];
	assign scl_s = pins_s[2];
	assign sda_s = pins_s[1];
	assign addr_sel_s = pins_s[0];

	// Oversampling at 125 MHz leaves dozens of cycles per SCL phase even at 1 MHz
	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;
	assign i2c_en = cs_s & cs_prev_reg & ~i2c_disable_i;
	assign start_cond = i2c_en & scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign stop_cond = i2c_en & scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	assign rx_byte = {shift_reg[6:0], sda_s};
	assign addr_match = (shift_reg[6:0] == {`TARGET_ADDR_HI, addr_sel_s});

	always_comb
	begin
		state_next = state_reg;
		phase_next = phase_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		tx_next = tx_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		rw_next = rw_reg;
		wr_next = 1'b0;
		rd_next = 1'b0;
		sda_out_next = sda_out_reg;
		sda_oe_next = sda_oe_reg;
		sdo_out_next = sdo_out_reg;
		sdo_oe_next = sdo_oe_reg;
		scl_prev_next = scl_s;
		sda_prev_next = sda_s;
		cs_prev_next = cs_s;

		// Fetched byte lands one cycle after the read strobe, well before the next SCL fall
		if (rd_reg)
		begin
			tx_next = reg_rdata_i;
		end
		// With auto-increment set, the address steps after each byte block once the strobe has used it
		if ((rd_reg | wr_reg) & auto_inc_i)
		begin
			addr_next = addr_reg + `ADDR_STEP;
		end

		if (!cs_s)
		begin
			state_next = serial_port_pkg::st_idle;
			if (cs_prev_reg)
			begin
				phase_next = serial_port_pkg::ph_cmd;
				bit_cnt_next = `BIT_FIRST;
				sda_oe_next = 1'b0;
			end
			else if (scl_rise)
			begin
				shift_next = rx_byte;
				bit_cnt_next = bit_cnt_reg + 3'h1;
				if (bit_cnt_reg == `BIT_LAST)
				begin
					if (phase_reg == serial_port_pkg::ph_cmd)
					begin
						rw_next = shift_reg[6];
						addr_next = {1'b0, shift_reg[5:0], sda_s};
						phase_next = serial_port_pkg::ph_data;
						rd_next = (shift_reg[6] == `DIR_READ);
					end
					else if (rw_reg == `DIR_READ)
					begin
						rd_next = 1'b1;
					end
					else
					begin
						wdata_next = rx_byte;
						wr_next = 1'b1;
					end
				end
			end
			else if (scl_fall && phase_reg == serial_port_pkg::ph_data && rw_reg == `DIR_READ)
			begin
				// Works alike in modes 0 and 3: only edges after the command byte drive
				tx_next = {tx_reg[6:0], 1'b0};
				if (three_wire_select_i)
				begin
					sda_out_next = tx_reg[7];
					sda_oe_next = 1'b1;
					sdo_oe_next = 1'b0;
				end
				else
				begin
					sdo_out_next = tx_reg[7];
					sdo_oe_next = 1'b1;
					sda_oe_next = 1'b0;
				end
			end
		end
		else
		begin
			sdo_oe_next = 1'b0;
			if (!cs_prev_reg)
			begin
				// A partial byte is simply forgotten here
				sda_oe_next = 1'b0;
				phase_next = serial_port_pkg::ph_cmd;
				bit_cnt_next = `BIT_FIRST;
			end
			else if (!i2c_en)
			begin
				state_next = serial_port_pkg::st_idle;
				sda_oe_next = 1'b0;
			end
			else if (start_cond)
			begin
				state_next = serial_port_pkg::st_addr;
				bit_cnt_next = `BIT_FIRST;
				sda_oe_next = 1'b0;
			end
			else if (stop_cond)
			begin
				state_next = serial_port_pkg::st_idle;
				sda_oe_next = 1'b0;
			end
			else if (scl_rise)
			begin
				unique case (state_reg)
					serial_port_pkg::st_addr,
					serial_port_pkg::st_sub,
					serial_port_pkg::st_wdata:
					begin
						shift_next = rx_byte;
						bit_cnt_next = bit_cnt_reg + 3'h1;
						if (bit_cnt_reg == `BIT_LAST)
						begin
							if (state_reg == serial_port_pkg::st_addr)
							begin
								if (addr_match)
								begin
									rw_next = sda_s;
									rd_next = (sda_s == `DIR_READ);
									state_next = serial_port_pkg::st_addr_ack;
								end
								else
								begin
									state_next = serial_port_pkg::st_idle;
								end
							end
							else if (state_reg == serial_port_pkg::st_sub)
							begin
								addr_next = rx_byte;
								state_next = serial_port_pkg::st_sub_ack;
							end
							else
							begin
								wdata_next = rx_byte;
								wr_next = 1'b1;
								state_next = serial_port_pkg::st_wack;
							end
						end
					end
					serial_port_pkg::st_rack:
					begin
						if (sda_s != `ACK_LEVEL)
						begin
							state_next = serial_port_pkg::st_idle;
						end
						else
						begin
							rd_next = 1'b1;
						end
					end
					default:
					begin
					end
				endcase
			end
			else if (scl_fall)
			begin
				sda_out_next = `ACK_LEVEL;
				unique case (state_reg)
					serial_port_pkg::st_addr_ack,
					serial_port_pkg::st_sub_ack,
					serial_port_pkg::st_wack:
					begin
						if (!sda_oe_reg)
						begin
							sda_oe_next = 1'b1;
						end
						else if (state_reg == serial_port_pkg::st_addr_ack && rw_reg == `DIR_READ)
						begin
							sda_oe_next = ~tx_reg[7];
							tx_next = {tx_reg[6:0], 1'b0};
							bit_cnt_next = 3'h1;
							state_next = serial_port_pkg::st_rdata;
						end
						else
						begin
							sda_oe_next = 1'b0;
							bit_cnt_next = `BIT_FIRST;
							state_next = (state_reg == serial_port_pkg::st_addr_ack) ?
								serial_port_pkg::st_sub : serial_port_pkg::st_wdata;
						end
					end
					serial_port_pkg::st_rdata:
					begin
						if (bit_cnt_reg == `BIT_FIRST)
						begin
							sda_oe_next = 1'b0;
							state_next = serial_port_pkg::st_rack;
						end
						else
						begin
							sda_oe_next = ~tx_reg[7];
							tx_next = {tx_reg[6:0], 1'b0};
							bit_cnt_next = bit_cnt_reg + 3'h1;
						end
					end
					serial_port_pkg::st_rack:
					begin
						sda_oe_next = ~tx_reg[7];
						tx_next = {tx_reg[6:0], 1'b0};
						bit_cnt_next = 3'h1;
						state_next = serial_port_pkg::st_rdata;
					end
					default:
					begin
						sda_oe_next = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_s)
	begin
		if (!rst_n_s)
		begin
			state_reg <= serial_port_pkg::st_idle;
			phase_reg <= serial_port_pkg::ph_cmd;
			bit_cnt_reg <= `BIT_FIRST;
			shift_reg <= `BYTE_ZERO;
			tx_reg <= `BYTE_ZERO;
			addr_reg <= `BYTE_ZERO;
			wdata_reg <= `BYTE_ZERO;
			rw_reg <= 1'b0;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
			sda_out_reg <= 1'b1;
			sda_oe_reg <= 1'b0;
			sdo_out_reg <= 1'b1;
			sdo_oe_reg <= 1'b0;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			cs_prev_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			tx_reg <= tx_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			rw_reg <= rw_next;
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			sda_out_reg <= sda_out_next;
			sda_oe_reg <= sda_oe_next;
			sdo_out_reg <= sdo_out_next;
			sdo_oe_reg <= sdo_oe_next;
			scl_prev_reg <= scl_prev_next;
			sda_prev_reg <= sda_prev_next;
			cs_prev_reg <= cs_prev_next;
		end
	end

	assign sda_o = sda_out_reg;
	assign sda_oe_o = sda_oe_reg;
	assign sdo_o = sdo_out_reg;
	assign sdo_oe_o = sdo_oe_reg;
	assign reg_addr_o = addr_reg;
	assign reg_wdata_o = wdata_reg;
	assign reg_wr_o = wr_reg;
	assign reg_rd_o = rd_reg;

endmodule : serial_register_access_port

`default_nettype wire

// *** verification/serial_port_chk.sv ***
// Port checker for the serial register access port
`timescale 1ns/10ps
`default_nettype none
module serial_port_chk (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic chip_select_n_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic sdo_o,
	input wire logic sdo_oe_o,
	input wire logic three_wire_select_i,
	input wire logic i2c_disable_i,
	input wire logic reg_wr_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	property p_wr_pulse;
		reg_wr_o |=> !reg_wr_o;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write strobe too long");
	property p_ack_low;
		chip_select_n_i [*4] ##0 sda_oe_o |-> !sda_o;
	endproperty
	a_ack_low: assert property (p_ack_low)
		else $error("I2C drive not low");
	property p_i2c_off;
		(i2c_disable_i && chip_select_n_i) [*4] |-> !sda_oe_o;
	endproperty
	a_i2c_off: assert property (p_i2c_off)
		else $error("SDA driven while I2C off");
	property p_w4_no_sda;
		(!chip_select_n_i && !three_wire_select_i) [*4] |-> !sda_oe_o;
	endproperty
	a_w4_no_sda: assert property (p_w4_no_sda)
		else $error("SDA driven in 4-wire SPI");
	property p_wr_no_drive;
		reg_wr_o |-> !sdo_oe_o && !sda_oe_o;
	endproperty
	a_wr_no_drive: assert property (p_wr_no_drive)
		else $error("pin driven during write");
	property p_oe_release;
		$rose(chip_select_n_i) |-> ##3 !sdo_oe_o && !sda_oe_o;
	endproperty
	a_oe_release: assert property (p_oe_release)
		else $error("data pin held after CS rise");
	property p_sdo_on_low;
		sdo_oe_o && $past(sdo_oe_o) && $changed(sdo_o) |-> !scl_i;
	endproperty
	a_sdo_on_low: assert property (p_sdo_on_low)
		else $error("SDO changed with clock high");
	property p_oe_start;
		$rose(sdo_oe_o) |-> !chip_select_n_i && !scl_i;
	endproperty
	a_oe_start: assert property (p_oe_start)
		else $error("SDO enabled outside bit 8 start");
endmodule : serial_port_chk

bind serial_register_access_port serial_port_chk serial_port_chk_inst (.ref_clk_i, .rst_n_i,
	.chip_select_n_i, .scl_i, .sda_o, .sda_oe_o, .sdo_o, .sdo_oe_o, .three_wire_select_i,
	.i2c_disable_i, .reg_wr_o);
`default_nettype wire

// *** verification/host_model.sv ***
// Host controller model for the shared SPI and I2C pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	output logic cs_n_o,
	output logic scl_o,
	output logic sda_o,
	output logic sda_oe_o
);
	int lo = 63;
	int hi = 60;
	bit three_wire = 1'b0;
	initial
	begin
		cs_n_o = 1'b1;
		scl_o = 1'b1;
		sda_o = 1'b0;
		sda_oe_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// Mode 0 parks the clock low before CS falls
	task automatic spi(input logic m3, input int n, input logic [23:0] tx,
		output logic [15:0] rx);
		rx = 16'h0000;
		scl_o <= m3;
		tick(5);
		cs_n_o <= 1'b0;
		tick(5);
		for (int i = 0; i < n; i++)
		begin
			scl_o <= 1'b0;
			sda_o <= tx[23-i];
			sda_oe_o <= !(three_wire && tx[23] && i > 7);
			tick(5);
			if (i > 7)
				rx = {rx[14:0], three_wire ? sda_i : (sdo_oe_i ? sdo_i : 1'bx)};
			scl_o <= 1'b1;
			tick(5);
		end
		cs_n_o <= 1'b1;
		sda_oe_o <= 1'b0;
		sda_o <= 1'b0;
		tick(5);
	endtask : spi
	// Open drain: a one only releases the line
	task automatic i2c_bit(input logic v, output logic s);
		tick(2);
		sda_oe_o <= !v;
		tick(lo);
		scl_o <= 1'b1;
		tick(hi);
		s = sda_i;
		scl_o <= 1'b0;
	endtask : i2c_bit
	task automatic i2c_byte(input logic [7:0] b, input logic a, output logic [7:0] r,
		output logic s);
		for (int i = 7; i >= 0; i--)
			i2c_bit(b[i], r[i]);
		i2c_bit(a, s);
	endtask : i2c_byte
	task automatic start();
		tick(2);
		sda_oe_o <= 1'b0;
		tick(lo);
		scl_o <= 1'b1;
		tick(hi);
		sda_oe_o <= 1'b1;
		tick(hi);
		scl_o <= 1'b0;
	endtask : start
	task automatic stop();
		tick(2);
		sda_oe_o <= 1'b1;
		tick(lo);
		scl_o <= 1'b1;
		tick(hi);
		sda_oe_o <= 1'b0;
		tick(lo);
	endtask : stop
endmodule : host_model
`default_nettype wire

// *** verification/serial_register_access_port_tb.sv ***
// Self-checking bench for the serial register access port
`timescale 1ns/10ps
`default_nettype none
module serial_register_access_port_tb;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic auto_inc_i = 1'b0;
	logic three_wire_select_i = 1'b0;
	logic i2c_disable_i = 1'b0;
	logic address_select_pin_i = 1'b1;
	logic [7:0] reg_rdata_i;
	logic cs_n, scl, h_sda, h_oe, sda_w, sda_o, sda_oe_o, sdo_o, sdo_oe_o, reg_wr_o, reg_rd_o;
	logic [7:0] reg_addr_o, reg_wdata_o;
	logic [7:0] mem [256];
	logic [7:0] exp_mem [256];
	int fails = 0;
	int checks = 0;
	always #4 ref_clk_i = ~ref_clk_i;
	// Pull-up holds the wire high when nobody drives it
	assign sda_w = (!sda_oe_o || sda_o) && (!h_oe || h_sda);
	serial_register_access_port serial_register_access_port_inst (.ref_clk_i, .rst_n_i,
		.chip_select_n_i(cs_n), .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_o,
		.address_select_pin_i, .sdo_o, .sdo_oe_o, .auto_inc_i, .three_wire_select_i,
		.i2c_disable_i, .reg_addr_o, .reg_wdata_o, .reg_wr_o, .reg_rd_o, .reg_rdata_i);
	host_model host_model_inst (.clk_i(ref_clk_i), .sda_i(sda_w), .sdo_i(sdo_o),
		.sdo_oe_i(sdo_oe_o), .cs_n_o(cs_n), .scl_o(scl), .sda_o(h_sda), .sda_oe_o(h_oe));
	// Read data stands while the strobe is high: the port takes it at the strobe's last edge
	assign reg_rdata_i = mem[reg_addr_o];
	always @(posedge ref_clk_i)
	begin
		if (reg_wr_o)
			mem[reg_addr_o] <= reg_wdata_o;
	end
	function automatic logic [7:0] nxt(input logic [7:0] a);
		return a + (auto_inc_i ? 8'h01 : 8'h00);
	endfunction : nxt
	task automatic end_sim();
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] got, input logic [7:0] want);
		checks++;
		if (got !== want)
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask : chk
	task automatic wb(input logic [7:0] b, input logic want);
		logic [7:0] r;
		logic s;
		host_model_inst.i2c_byte(b, 1'b1, r, s);
		chk({7'h00, s}, {7'h00, want});
	endtask : wb
	initial
	begin
		#800_000;
		fails++;
		end_sim();
	end
	initial
	begin
		logic [7:0] a, d1, d2, r1, r2;
		logic [15:0] rx;
		logic s;
		void'($urandom(93));
		for (int i = 0; i < 256; i++)
		begin
			mem[i] = 8'($urandom);
			exp_mem[i] = mem[i];
		end
		repeat (8) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		for (int k = 0; k < 8; k++)
		begin
			auto_inc_i <= k[1];
			three_wire_select_i <= k[2];
			host_model_inst.three_wire = k[2];
			a = 8'($urandom_range(0, 125));
			{d1, d2} = 16'($urandom);
			host_model_inst.spi(k[0], 24, {1'b0, a[6:0], d1, d2}, rx);
			exp_mem[a] = d1;
			exp_mem[nxt(a)] = d2;
			host_model_inst.spi(k[0], 24, {1'b1, a[6:0], 16'h0000}, rx);
			chk(rx[15:8], exp_mem[a]);
			chk(rx[7:0], exp_mem[nxt(a)]);
		end
		host_model_inst.spi(1'b1, 12, {1'b0, a[6:0], ~exp_mem[a], 8'h00}, rx);
		host_model_inst.spi(1'b1, 16, {1'b1, a[6:0], 16'h0000}, rx);
		chk(rx[7:0], exp_mem[a]);
		for (int k = 0; k < 2; k++)
		begin
			address_select_pin_i <= k[0];
			auto_inc_i <= !k[0];
			host_model_inst.lo = k ? 63 : 200;
			host_model_inst.hi = k ? 60 : 111;
			a = 8'($urandom_range(0, 253));
			{d1, d2} = 16'($urandom);
			host_model_inst.start();
			wb({7'h6A | 7'(k), 1'b0}, 1'b0);
			wb(a, 1'b0);
			wb(d1, 1'b0);
			wb(d2, 1'b0);
			host_model_inst.stop();
			exp_mem[a] = d1;
			exp_mem[nxt(a)] = d2;
			host_model_inst.start();
			wb({7'h6A | 7'(k), 1'b0}, 1'b0);
			wb(a, 1'b0);
			host_model_inst.start();
			wb({7'h6A | 7'(k), 1'b1}, 1'b0);
			host_model_inst.i2c_byte(8'hFF, 1'b0, r1, s);
			host_model_inst.i2c_byte(8'hFF, 1'b1, r2, s);
			host_model_inst.stop();
			chk(r1, exp_mem[a]);
			chk(r2, exp_mem[nxt(a)]);
			host_model_inst.start();
			wb({7'h6A | 7'(!k), 1'b0}, 1'b1);
			host_model_inst.stop();
		end
		i2c_disable_i <= 1'b1;
		host_model_inst.start();
		wb({7'h6B, 1'b0}, 1'b1);
		host_model_inst.stop();
		end_sim();
	end
endmodule : serial_register_access_port_tb
`default_nettype wire
